/* File: common/irq_seq_cfg.svh */
// Constants of the interrupt sequencer and vector generators
//
// Operation
// R1 - Each maskable source has its own enable; global_irq_enable masks all.
// R2 - Maskable needs enable and global_irq_enable; non-maskable only enable.
// R3 - Acceptance to first service instruction takes exactly six cycles.
// R4 - Finish instruction, push program_counter, then push status word.
// R5 - Highest fixed priority pending request is the one serviced.
// R6 - Single-source flag cleared on acceptance; multi-source flags stay.
// R7 - Acceptance clears status word except sysclk_gen_ctrl_low.
// R8 - Last step loads program_counter from the selected vector word.
// R9 - Instruction after enable_irq_instr always runs before servicing.
// R10 - Software keeps one instruction between enable and disable of irqs.
// R11 - return_from_irq_instr takes five cycles: pop status, then pop PC.
// R12 - Popped status word fully takes effect after return.
// R13 - global_irq_enable set in a service routine allows any preemption.
// R14 - Vectors occupy word addresses 0FF80h to 0FFFFh, 64 sources.
// R15 - Reset vector 0FFFEh highest, system_nmi 0FFFCh, user_nmi 0FFFAh.
// R16 - Special function registers accept byte and word accesses.
// R17 - vector_remap_to_ram redirects vector fetches to top of RAM.
// R18 - vector_remap_to_ram clears on every brownout_reset.
// R19 - Three vector registers report highest enabled pending flag.
// R20 - Reading a vector register clears the flag it reports.
// R21 - Remaining flags raise a new interrupt after servicing.
// R22 - Writing a vector register clears all flags of its group.
// R23 - Accepted non-maskable level blocks further sources of that level.
// R24 - Vector register reads zero, else even value rising as priority falls.
`ifndef IRQ_SEQ_CFG_SVH
`define IRQ_SEQ_CFG_SVH
`define SR_GIE      3
`define SR_CPU_HALT_BIT   4
`define SR_SYSCLK_GEN_CTRL_LOW     6
`define SR_RST      16'h0000
`define VEC_RESET   16'hFFFE
`define VEC_LOWEST  16'hFF80
`define RAM_VEC_TOP 16'h2FFE
`define IV_STEP     16'h0002
`define SLOT_RST    6'h00
`define SLOT_SYSTEM_NMI   6'h01
`define SLOT_USER_NMI   6'h02
`define SLOT_IRQ0   6'h03
`define ADR_SYSTEM_CONTROL_REG  3'h0
`define ADR_IRQ_EN  3'h1
`define ADR_GRP_EN  3'h2
`define ADR_RST_IV  3'h3
`define ADR_SYSTEM_NMI_IV 3'h4
`define ADR_USER_NMI_IV 3'h5
`define ADR_STATUS  3'h6
`define REMAP_BIT   0
`define GEN_RST_LSB  0
`define GEN_SYSTEM_NMI_LSB 8
`define GEN_USER_NMI_LSB 16
`endif

/* File: common/irq_seq_pkg.sv */
// Types of the interrupt sequencer
package irq_seq_pkg;
   typedef enum logic [11:0] {
      S_IDLE    = 12'h001,
      S_PUSH_PC = 12'h002,
      S_PUSH_SR = 12'h004,
      S_CLR     = 12'h008,
      S_FETCH   = 12'h010,
      S_WAIT    = 12'h020,
      S_LOAD    = 12'h040,
      S_R_SR    = 12'h080,
      S_R_SRW   = 12'h100,
      S_R_PC    = 12'h200,
      S_R_PCW   = 12'h400,
      S_R_LOAD  = 12'h800
   } seq_state_t;
endpackage

/* File: design/nmi_vec_gen.sv */
// Flag group with priority vector, read and write side effects
`timescale 1ns/1ps
`default_nettype none
`include "irq_seq_cfg.svh"
module nmi_vec_gen #(
   parameter int N = 4
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Flag sources and enables
   input  wire logic [N-1:0] set_i,
   input  wire logic [N-1:0] en_i,
   // Register side effects
   input  wire logic         rd_i,
   input  wire logic         wr_i,
   // Vector value
   output logic      [15:0]  vec_o,
   output logic              pend_o
);
   typedef struct packed {
      logic [N-1:0] flag;
   } vg_st_t;

   vg_st_t       s_r;
   vg_st_t       s_nxt;
   logic [N-1:0] top;

   always_comb begin
      s_nxt = s_r;
      top   = '0;
      vec_o = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (s_r.flag[i] && en_i[i]) begin
            top    = '0;
            top[i] = 1'b1;
            vec_o  = 16'(i + 1) * `IV_STEP; // R19 R24
         end
      end
      pend_o = |(s_r.flag & en_i); // R21
      if (wr_i) begin
         s_nxt.flag = '0; // R22
      end else if (rd_i) begin
         s_nxt.flag = s_r.flag & ~top; // R20
      end
      s_nxt.flag = s_nxt.flag | set_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_rd_clears_top: assert property (rd_i && !wr_i && set_i == '0 |=> // R20
      (s_r.flag & $past(top)) == '0) else $error("read left reported flag");
   a_wr_clears_all: assert property (wr_i && set_i == '0 |=> // R22
      s_r.flag == '0) else $error("write left a flag");
   a_vec_even: assert property (pend_o |-> vec_o != '0 && !vec_o[0]) // R24
      else $error("vector not even and nonzero");
endmodule // nmi_vec_gen
`default_nettype wire

/* File: design/irq_sequencer.sv */
// Interrupt accept and return sequencer with vector generators
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "irq_seq_cfg.svh"
module irq_sequencer
   import irq_seq_pkg::*;
#(
   parameter int                N_IRQ      = 8,
   parameter int                N_SYSTEM_NMI     = 4,
   parameter int                N_USER_NMI     = 4,
   parameter int                N_RST      = 4,
   parameter logic [N_IRQ-1:0]  SINGLE_SRC = '1
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Wishbone slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [4:2]        adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   // Interrupt sources
   input  wire logic [N_IRQ-1:0]  irq_req_i,
   output logic      [N_IRQ-1:0]  irq_ack_o,
   input  wire logic [N_SYSTEM_NMI-1:0] system_nmi_set_i,
   input  wire logic [N_USER_NMI-1:0] user_nmi_set_i,
   input  wire logic [N_RST-1:0]  rst_cause_i,
   // CPU core
   input  wire logic              instr_done_i,
   input  wire logic              instr_is_enable_irq_instr_i,
   input  wire logic              instr_is_return_from_irq_instr_i,
   input  wire logic [15:0]       pc_i,
   input  wire logic              sr_we_i,
   input  wire logic [15:0]       sr_wdata_i,
   output logic      [15:0]       status_word_o,
   output logic                   cpu_hold_o,
   output logic                   pc_load_o,
   output logic      [15:0]       pc_o,
   // Stack and vector memory
   output logic                   stack_push_o,
   output logic                   stack_pop_o,
   output logic      [15:0]       stack_wdata_o,
   input  wire logic [15:0]       stack_rdata_i,
   output logic                   vec_rd_o,
   output logic      [15:0]       vec_addr_o,
   input  wire logic [15:0]       vec_data_i
);
   typedef struct packed {
      seq_state_t        state;
      logic [5:0]        slot;
      logic [15:0]       vaddr;
      logic [15:0]       data;
      logic [15:0]       sr;
      logic              remap;
      logic [N_IRQ-1:0]  irq_en;
      logic [23:0]       grp_en;
      logic              system_nmi_blk;
      logic              user_nmi_blk;
      logic              ack;
      logic [31:0]       dat;
   } st_t;

   st_t              s_r;
   st_t              s_nxt;
   logic             global_irq_enable;
   logic [N_IRQ-1:0] irq_live;
   logic             system_nmi_pend;
   logic             user_nmi_pend;
   logic             rst_pend;
   logic             system_nmi_live;
   logic             user_nmi_live;
   logic             any_req;
   logic [5:0]       sel_slot;
   logic             accept;
   logic             ret_go;
   logic             bus_go;
   logic [2:0]       iv_rd;
   logic [2:0]       iv_wr;
   logic [15:0]      rst_iv;
   logic [15:0]      system_nmi_iv;
   logic [15:0]      user_nmi_iv;
   logic [15:0]      vbase;

   function automatic logic [31:0] lanes(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   assign global_irq_enable       = s_r.sr[`SR_GIE];
   assign irq_live  = irq_req_i & s_r.irq_en & {N_IRQ{global_irq_enable}}; // R1 R2 R13
   assign system_nmi_live = system_nmi_pend && !s_r.system_nmi_blk; // R2 R23
   assign user_nmi_live = user_nmi_pend && !s_r.user_nmi_blk && !s_r.system_nmi_blk; // R2 R23
   assign any_req   = system_nmi_live || user_nmi_live || (|irq_live);
   assign accept    = s_r.state == S_IDLE && instr_done_i && !instr_is_enable_irq_instr_i
                      && !instr_is_return_from_irq_instr_i && any_req; // R4 R9
   assign ret_go    = s_r.state == S_IDLE && instr_done_i && instr_is_return_from_irq_instr_i;
   assign bus_go    = cyc_i && stb_i && !s_r.ack;
   assign vbase     = s_r.remap ? `RAM_VEC_TOP : `VEC_RESET; // R17

   // Fixed priority: system_nmi, user_nmi, then maskable by index
   always_comb begin
      sel_slot = `SLOT_IRQ0;
      for (int i = N_IRQ - 1; i >= 0; i--) begin
         if (irq_live[i]) begin
            sel_slot = `SLOT_IRQ0 + 6'(i); // R5
         end
      end
      if (user_nmi_live) begin
         sel_slot = `SLOT_USER_NMI; // R15
      end
      if (system_nmi_live) begin
         sel_slot = `SLOT_SYSTEM_NMI; // R15
      end
   end

   always_comb begin
      iv_rd = '0;
      iv_wr = '0;
      if (bus_go) begin
         iv_rd[0] = !we_i && adr_i == `ADR_RST_IV; // R20
         iv_rd[1] = !we_i && adr_i == `ADR_SYSTEM_NMI_IV; // R20
         iv_rd[2] = !we_i && adr_i == `ADR_USER_NMI_IV; // R20
         iv_wr[0] = we_i && adr_i == `ADR_RST_IV; // R22
         iv_wr[1] = we_i && adr_i == `ADR_SYSTEM_NMI_IV; // R22
         iv_wr[2] = we_i && adr_i == `ADR_USER_NMI_IV; // R22
      end
   end

   nmi_vec_gen #(.N(N_RST)) u_rst_iv (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .set_i  (rst_cause_i),
      .en_i   (s_r.grp_en[`GEN_RST_LSB +: N_RST]),
      .rd_i   (iv_rd[0]),
      .wr_i   (iv_wr[0]),
      .vec_o  (rst_iv),
      .pend_o (rst_pend)
   );

   nmi_vec_gen #(.N(N_SYSTEM_NMI)) u_system_nmi_iv (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .set_i  (system_nmi_set_i),
      .en_i   (s_r.grp_en[`GEN_SYSTEM_NMI_LSB +: N_SYSTEM_NMI]),
      .rd_i   (iv_rd[1]),
      .wr_i   (iv_wr[1]),
      .vec_o  (system_nmi_iv),
      .pend_o (system_nmi_pend)
   );

   nmi_vec_gen #(.N(N_USER_NMI)) u_user_nmi_iv (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .set_i  (user_nmi_set_i),
      .en_i   (s_r.grp_en[`GEN_USER_NMI_LSB +: N_USER_NMI]),
      .rd_i   (iv_rd[2]),
      .wr_i   (iv_wr[2]),
      .vec_o  (user_nmi_iv),
      .pend_o (user_nmi_pend)
   );

   always_comb begin
      s_nxt     = s_r;
      s_nxt.ack = bus_go;
      if (sr_we_i && s_r.state == S_IDLE) begin
         s_nxt.sr = sr_wdata_i;
      end
      unique case (s_r.state)
         S_IDLE: begin
            if (accept) begin
               s_nxt.state = S_PUSH_PC;
               s_nxt.slot  = sel_slot; // R5
               s_nxt.data  = pc_i;
               s_nxt.vaddr = vbase - {9'h000, sel_slot, 1'b0}; // R14 R17
            end else if (ret_go) begin
               s_nxt.state = S_R_SR;
            end
         end
         S_PUSH_PC: begin
            s_nxt.state = S_PUSH_SR;
            s_nxt.data  = s_r.sr;
         end
         S_PUSH_SR: begin
            s_nxt.state = S_CLR;
            s_nxt.sr    = s_r.sr & (16'h0001 << `SR_SYSCLK_GEN_CTRL_LOW); // R7
            if (s_r.slot == `SLOT_SYSTEM_NMI) begin
               s_nxt.system_nmi_blk = 1'b1; // R23
            end
            if (s_r.slot == `SLOT_USER_NMI) begin
               s_nxt.user_nmi_blk = 1'b1; // R23
            end
         end
         S_CLR: s_nxt.state = S_FETCH;
         S_FETCH: s_nxt.state = S_WAIT;
         S_WAIT: begin
            s_nxt.state = S_LOAD;
            s_nxt.data  = vec_data_i; // R8
         end
         S_LOAD: s_nxt.state = S_IDLE;
         S_R_SR: s_nxt.state = S_R_SRW;
         S_R_SRW: begin
            s_nxt.state    = S_R_PC;
            s_nxt.sr       = stack_rdata_i; // R12
            s_nxt.system_nmi_blk = 1'b0;
            s_nxt.user_nmi_blk = s_r.system_nmi_blk ? s_r.user_nmi_blk : 1'b0;
         end
         S_R_PC: s_nxt.state = S_R_PCW;
         S_R_PCW: begin
            s_nxt.state = S_R_LOAD;
            s_nxt.data  = stack_rdata_i; // R11
         end
         S_R_LOAD: s_nxt.state = S_IDLE;
      endcase
      if (bus_go) begin
         s_nxt.dat = '0;
         if (we_i) begin
            unique case (adr_i)
               `ADR_SYSTEM_CONTROL_REG: s_nxt.remap =
                  sel_i[0] ? dat_i[`REMAP_BIT] : s_r.remap; // R16
               `ADR_IRQ_EN: s_nxt.irq_en = N_IRQ'(
                  lanes(32'(s_r.irq_en), dat_i, sel_i)); // R16
               `ADR_GRP_EN: s_nxt.grp_en =
                  24'(lanes({8'h00, s_r.grp_en}, dat_i, sel_i)); // R16
               default: s_nxt.dat = '0;
            endcase
         end else begin
            unique case (adr_i)
               `ADR_SYSTEM_CONTROL_REG:  s_nxt.dat = {31'h0, s_r.remap};
               `ADR_IRQ_EN:  s_nxt.dat = 32'(s_r.irq_en);
               `ADR_GRP_EN:  s_nxt.dat = {8'h00, s_r.grp_en};
               `ADR_RST_IV:  s_nxt.dat = {16'h0000, rst_iv}; // R19
               `ADR_SYSTEM_NMI_IV: s_nxt.dat = {16'h0000, system_nmi_iv}; // R19
               `ADR_USER_NMI_IV: s_nxt.dat = {16'h0000, user_nmi_iv}; // R19
               `ADR_STATUS:  s_nxt.dat = {4'h0, s_r.state, s_r.sr};
               default:      s_nxt.dat = '0;
            endcase
         end
      end
   end

   // Reset starts the reset vector fetch directly
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r          <= '0;
         s_r.state    <= S_FETCH; // R15
         s_r.slot     <= `SLOT_RST;
         s_r.vaddr    <= `VEC_RESET; // R15
         s_r.sr       <= `SR_RST;
         s_r.remap    <= 1'b0; // R18
      end else begin
         s_r <= s_nxt;
      end
   end

   generate
      for (genvar g = 0; g < N_IRQ; g++) begin : g_ack
         assign irq_ack_o[g] = s_r.state == S_CLR && SINGLE_SRC[g]
                               && s_r.slot == `SLOT_IRQ0 + 6'(g); // R6
      end
   endgenerate

   assign dat_o         = s_r.dat;
   assign ack_o         = s_r.ack;
   assign status_word_o = s_r.sr;
   assign cpu_hold_o    = s_r.state != S_IDLE; // R3 R11
   assign pc_load_o     = s_r.state == S_LOAD || s_r.state == S_R_LOAD; // R8
   assign pc_o          = s_r.data;
   assign stack_push_o  = s_r.state == S_PUSH_PC || s_r.state == S_PUSH_SR; // R4
   assign stack_pop_o   = s_r.state == S_R_SR || s_r.state == S_R_PC; // R11
   assign stack_wdata_o = s_r.data;
   assign vec_rd_o      = s_r.state == S_FETCH;
   assign vec_addr_o    = s_r.vaddr;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_acc_six_cycles: assert property (accept |=> // R3
      cpu_hold_o [*6] ##1 !cpu_hold_o) else $error("acceptance not six cycles");
   a_ret_five_cycles: assert property (ret_go |=> // R11
      cpu_hold_o [*5] ##1 !cpu_hold_o) else $error("return not five cycles");
   a_push_pc_sr: assert property (accept |=> stack_push_o // R4
      && stack_wdata_o == $past(pc_i) ##1 stack_push_o
      && stack_wdata_o == $past(s_r.sr)) else $error("push order wrong");
   a_gie_gate: assert property (accept && sel_slot >= `SLOT_IRQ0 |-> // R2
      global_irq_enable) else $error("maskable taken with gie clear");
   a_sr_cleared: assert property (s_r.state == S_PUSH_SR |=> // R7
      s_r.sr == ($past(s_r.sr) & (16'h0001 << `SR_SYSCLK_GEN_CTRL_LOW)))
      else $error("status word not cleared");
   a_enable_irq_instr_shadow: assert property (instr_done_i && instr_is_enable_irq_instr_i |-> // R9
      !accept) else $error("accepted after enable instruction");
   a_sr_restored: assert property (s_r.state == S_R_SR ##1 1'b1 |=> // R12
      s_r.sr == $past(stack_rdata_i)) else $error("status word not restored");
   a_vec_loaded: assert property (s_r.state == S_WAIT |=> pc_load_o // R8
      && pc_o == $past(vec_data_i)) else $error("vector not loaded");
   a_vec_range: assert property (vec_rd_o && !s_r.remap |-> // R14
      vec_addr_o >= `VEC_LOWEST) else $error("vector out of range");
   a_reset_fetch: assert property ($fell(rst_i) |-> vec_rd_o // R15
      && vec_addr_o == `VEC_RESET) else $error("reset vector not fetched");
   a_system_nmi_block: assert property (accept && sel_slot == `SLOT_SYSTEM_NMI |-> // R23
      ##3 s_r.system_nmi_blk) else $error("system nmi not blocked");
   a_system_nmi_first: assert property (accept && system_nmi_live |-> // R5
      sel_slot == `SLOT_SYSTEM_NMI) else $error("priority wrong");

   c_accept: cover property (accept);
   c_return: cover property (ret_go);
   c_remap_fetch: cover property (vec_rd_o && s_r.remap);
   c_nested: cover property (accept && s_r.sr[`SR_GIE] && s_r.data != '0);
endmodule // irq_sequencer
`default_nettype wire

/* File: bench/stack_vec_mem.sv */
// Stack and vector memory model beside the sequencer
`timescale 1ns/1ps
`default_nettype none
module stack_vec_mem (
   // Clock
   input  wire logic        clk_i,
   // Stack port
   input  wire logic        push_i,
   input  wire logic        pop_i,
   input  wire logic [15:0] wdata_i,
   output logic      [15:0] rdata_o = 16'h0000,
   // Vector port
   input  wire logic        rd_i,
   input  wire logic [15:0] addr_i,
   output logic      [15:0] data_o = 16'h0000
);
   logic [15:0] mem [16];
   logic [3:0]  sp = 4'h0;
   // Data not just read inverts each cycle
   always @(posedge clk_i) begin
      if (push_i) begin
         mem[sp] <= wdata_i;
         sp <= sp + 4'h1;
      end
      if (pop_i) begin
         rdata_o <= mem[sp - 4'h1];
         sp <= sp - 4'h1;
      end else begin
         rdata_o <= ~rdata_o;
      end
      data_o <= rd_i ? ~addr_i : ~data_o;
   end
endmodule // stack_vec_mem
`default_nettype wire

/* File: bench/interrupt_sequencer_vector_gen_bench.sv */
// Self-checking bench of the interrupt sequencer and vector generators
`timescale 1ns/1ps
`default_nettype none
module interrupt_sequencer_vector_gen_bench;
   typedef logic [7:0][5:0] pat_t;
   localparam pat_t P_ACC = {6'h00, 6'h00, 6'h21, 6'h20, 6'h22, 6'h24, 6'h30, 6'h30};
   localparam pat_t P_NMI = {6'h00, 6'h00, 6'h21, 6'h20, 6'h22, 6'h20, 6'h30, 6'h30};
   localparam pat_t P_RET = {6'h00, 6'h00, 6'h00, 6'h21, 6'h20, 6'h28, 6'h20, 6'h28};
   localparam pat_t P_RST = {6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h21, 6'h20, 6'h22};
   localparam pat_t P_NONE = 48'h0;
   logic        clk_i = 1'h0;
   logic        rst_i = 1'h1;
   logic        cyc_i = 1'h0;
   logic        stb_i = 1'h0;
   logic        we_i = 1'h0;
   logic [4:2]  adr_i = 3'h0;
   logic [3:0]  sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0;
   logic [7:0]  irq_req_i = 8'h00;
   logic [3:0]  system_nmi_set_i = 4'h0;
   logic [3:0]  user_nmi_set_i = 4'h0;
   logic [3:0]  rst_cause_i = 4'h0;
   logic        instr_done_i = 1'h0;
   logic        instr_is_enable_irq_instr_i = 1'h0;
   logic        instr_is_return_from_irq_instr_i = 1'h0;
   logic [15:0] pc_i = 16'h0;
   logic        sr_we_i = 1'h0;
   logic [15:0] sr_wdata_i = 16'h0;
   logic [31:0] dat_o, rd;
   logic [7:0]  irq_ack_o;
   logic        ack_o, cpu_hold_o, pc_load_o, stack_push_o, stack_pop_o, vec_rd_o;
   logic [15:0] status_word_o, pc_o, stack_wdata_o, stack_rdata_i, vec_addr_o, vec_data_i;
   logic [15:0] cap_w [8], cap_a [8], cap_p [8], pc1, pc2;
   logic [7:0]  cap_k [8];
   int          num_errors = 0, comparisons = 0, a, b, m, en, f, g;

   irq_sequencer uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .irq_req_i(irq_req_i), .irq_ack_o(irq_ack_o),
      .system_nmi_set_i(system_nmi_set_i), .user_nmi_set_i(user_nmi_set_i), .rst_cause_i(rst_cause_i),
      .instr_done_i(instr_done_i), .instr_is_enable_irq_instr_i(instr_is_enable_irq_instr_i),
      .instr_is_return_from_irq_instr_i(instr_is_return_from_irq_instr_i), .pc_i(pc_i), .sr_we_i(sr_we_i),
      .sr_wdata_i(sr_wdata_i), .status_word_o(status_word_o), .cpu_hold_o(cpu_hold_o),
      .pc_load_o(pc_load_o), .pc_o(pc_o), .stack_push_o(stack_push_o),
      .stack_pop_o(stack_pop_o), .stack_wdata_o(stack_wdata_o),
      .stack_rdata_i(stack_rdata_i), .vec_rd_o(vec_rd_o), .vec_addr_o(vec_addr_o),
      .vec_data_i(vec_data_i));
   stack_vec_mem far (.clk_i(clk_i), .push_i(stack_push_o), .pop_i(stack_pop_o),
      .wdata_i(stack_wdata_o), .rdata_o(stack_rdata_i), .rd_i(vec_rd_o),
      .addr_i(vec_addr_o), .data_o(vec_data_i));

   always #10 clk_i = ~clk_i;

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [2:0] ad, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i <= w;
      adr_i <= ad;
      dat_i <= d;
      for (n = 0; n < 16; n++) begin
         @(posedge clk_i);
         #1;
         if (ack_o === 1'h1) break;
      end
      if (n == 16) begin
         num_errors++;
         end_sim;
      end
      // Ack was seen high just after the last edge; request held until the coming edge
      rd = dat_o;
      @(posedge clk_i);
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
   endtask

   task automatic setsr(input logic [15:0] v);
      @(posedge clk_i);
      sr_we_i <= 1'h1;
      sr_wdata_i <= v;
      @(posedge clk_i);
      sr_we_i <= 1'h0;
   endtask

   task automatic pulse(input int gi, input logic [3:0] mk);
      @(posedge clk_i);
      rst_cause_i <= gi == 0 ? mk : 4'h0;
      system_nmi_set_i <= gi == 1 ? mk : 4'h0;
      user_nmi_set_i <= gi == 2 ? mk : 4'h0;
      @(posedge clk_i);
      rst_cause_i <= 4'h0;
      system_nmi_set_i <= 4'h0;
      user_nmi_set_i <= 4'h0;
   endtask

   // Strobes of eight cycles against a pattern
   task automatic trace(input pat_t p);
      for (int i = 0; i < 8; i++) begin
         #1;
         cap_w[i] = stack_wdata_o;
         cap_a[i] = vec_addr_o;
         cap_p[i] = pc_o;
         cap_k[i] = irq_ack_o;
         chk(32'({cpu_hold_o, stack_push_o, stack_pop_o, |irq_ack_o, vec_rd_o,
            pc_load_o}), 32'(p[i]));
         @(posedge clk_i);
      end
   endtask

   task automatic step(input logic e, input logic r, input logic [15:0] pc, input pat_t p);
      @(posedge clk_i);
      instr_done_i <= 1'h1;
      instr_is_enable_irq_instr_i <= e;
      instr_is_return_from_irq_instr_i <= r;
      pc_i <= pc;
      @(posedge clk_i);
      instr_done_i <= 1'h0;
      instr_is_enable_irq_instr_i <= 1'h0;
      instr_is_return_from_irq_instr_i <= 1'h0;
      trace(p);
   endtask

   task automatic acc(input logic [15:0] pc, input logic [15:0] sr, input logic [15:0] va,
      input logic [7:0] ak);
      step(1'h0, 1'h0, pc, ak == 8'h00 ? P_NMI : P_ACC);
      chk(32'(cap_w[0]), 32'(pc));
      chk(32'(cap_w[1]), 32'(sr));
      chk(32'(cap_k[2]), 32'(ak));
      chk(32'(cap_a[3]), 32'(va));
      chk({16'h0000, cap_p[5]}, {16'h0000, ~va});
      chk(32'(status_word_o), 32'(sr & 16'h0040));
   endtask

   task automatic ret(input logic [15:0] pc, input logic [15:0] sr);
      step(1'h0, 1'h1, 16'h0000, P_RET);
      chk(32'(cap_p[4]), 32'(pc));
      chk(32'(status_word_o), 32'(sr));
   endtask

   task automatic boot;
      rst_i <= 1'h1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'h0;
      for (int k = 0; k < 4; k++) begin
         #1;
         if (vec_rd_o === 1'h1) break;
         @(posedge clk_i);
      end
      trace(P_RST);
      chk(32'(cap_a[0]), 32'hFFFE);
      chk(32'(cap_p[2]), 32'h0001);
      wb(1'h0, 3'h0, 32'h0);
      chk(rd, 32'h0);
      wb(1'h0, 3'h7, 32'h0);
      chk(rd, 32'h0);
   endtask

   function automatic int low(input int v);
      for (int i = 0; i < 8; i++) if (v[i]) return i;
      return -1;
   endfunction

   initial begin
      #1000000;
      num_errors++;
      end_sim;
   end

   initial begin
      void'($urandom(67));
      boot;
      $display("test reset done");
      for (g = 0; g < 3; g++) begin
         en = $urandom & 15;
         m = $urandom & 15;
         wb(1'h1, 3'h2, {12'h000, 4'(en), 4'h0, 4'(en), 4'h0, 4'(en)});
         pulse(g, 4'(m));
         f = m & en;
         for (int j = 0; j < 5; j++) begin
            wb(1'h0, 3'(3 + g), 32'h0);
            chk(rd, f == 0 ? 32'h0 : 32'(2 * (low(f) + 1)));
            if (f != 0) f = f & ~(1 << low(f));
         end
         pulse(g, 4'hF);
         wb(1'h1, 3'(3 + g), 32'h0);
         wb(1'h0, 3'(3 + g), 32'h0);
         chk(rd, 32'h0);
      end
      $display("test vector registers done");
      a = $urandom % 7;
      b = a + 1 + $urandom % (7 - a);
      pc1 = 16'($urandom) & 16'hFFFE;
      pc2 = 16'($urandom) & 16'hFFFE;
      wb(1'h1, 3'h1, 32'h0);
      setsr(16'h0058);
      irq_req_i <= 8'((1 << a) | (1 << b));
      step(1'h0, 1'h0, pc1, P_NONE);
      wb(1'h1, 3'h1, 32'hFF);
      setsr(16'h0050);
      step(1'h0, 1'h0, pc1, P_NONE);
      setsr(16'h0058);
      step(1'h1, 1'h0, pc1, P_NONE);
      acc(pc1, 16'h0058, 16'hFFFE - 16'(2 * (3 + a)), 8'(1 << a));
      irq_req_i <= 8'(1 << b);
      setsr(16'h0008);
      acc(pc2, 16'h0008, 16'hFFFE - 16'(2 * (3 + b)), 8'(1 << b));
      irq_req_i <= 8'h00;
      ret(pc2, 16'h0008);
      setsr(16'h0000);
      ret(pc1, 16'h0058);
      $display("test maskable done");
      setsr(16'h0000);
      wb(1'h1, 3'h2, 32'h000F0F0F);
      pulse(1, 4'($urandom | 1));
      pulse(2, 4'h3);
      acc(pc1, 16'h0000, 16'hFFFC, 8'h00);
      step(1'h0, 1'h0, pc2, P_NONE);
      wb(1'h1, 3'h4, 32'h0);
      ret(pc1, 16'h0000);
      acc(pc2, 16'h0000, 16'hFFFA, 8'h00);
      wb(1'h1, 3'h5, 32'h0);
      ret(pc2, 16'h0000);
      step(1'h0, 1'h0, pc1, P_NONE);
      $display("test nmi done");
      wb(1'h1, 3'h0, 32'h1);
      wb(1'h0, 3'h0, 32'h0);
      chk(rd, 32'h1);
      setsr(16'h0008);
      irq_req_i <= 8'(1 << a);
      acc(pc1, 16'h0008, 16'h2FFE - 16'(2 * (3 + a)), 8'(1 << a));
      irq_req_i <= 8'h00;
      boot;
      $display("test remap done");
      end_sim;
   end
endmodule // interrupt_sequencer_vector_gen_bench
`default_nettype wire
